// File: design/ppsm_pkg.sv
package ppsm_pkg;

  // Power states of the sequencer
  typedef enum logic [3:0] {
    ST_LOW_POWER_OFF_STATE,
    ST_SELF_TEST,
    ST_QUICK_START_OFF_STATE,
    ST_POWER_UP,
    ST_RUN,
    ST_STANDBY,
    ST_WD_RESET,
    ST_FAULT_DOWN
  } ppsm_state_t;

  // Pin and comparator levels, all asynchronous to sys_clk
  typedef struct packed {
    logic standbyPin;
    logic powerOnPin;
    logic testModePin;
    logic externalFailInput;
    logic vinAboveUv;
    logic vinAboveOv;
    logic thermalShutdown;
  } ppsm_pins_t;

  // Software control fields
  typedef struct packed {
    logic ovloEnable;
    logic externalFailEnable;
    logic powerOnEdgeMode;
    logic quickPowerupSelect;
    logic standbyPolarityBit;
  } ppsm_ctrl_t;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIMIT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;

  // Field positions and reset values
  localparam int STATE_POS = 0;
  localparam int STERR_POS = 16;
  localparam ppsm_ctrl_t CTRL_RST = 5'h10;
  localparam logic [3:0] WD_LIMIT_RST = 4'h4;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WD_DELAY_NS = 30000;
  localparam int WD_DELAY_CYC = (WD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: design/ppsm_power_state_machine.sv
`timescale 1ns/100ps
module ppsm_power_state_machine #(
  parameter bit SAFETY_VARIANT = 1'b1,
  parameter int WD_CNT_W = 4,
  parameter int WD_TMR_W = 10
) (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire ppsm_pkg::ppsm_pins_t pins, // Pin and monitor levels
  input wire logic trimLoadError, // Trim load failed
  input wire logic configLoadError, // Configuration load failed
  input wire logic wdResetEvent, // Hard watchdog reset pulse
  input wire logic selfTestDone, // Self-test finished pulse
  input wire logic selfTestPass, // Self-test result
  input wire logic powerUpSeqDone, // Power-up sequence finished
  input wire logic powerDownDone, // Fault power-down finished
  output logic selfTestRun, // Self-test requested
  output logic powerUpRun, // Power-up sequence requested
  output logic faultDownRun, // Fault power-down requested
  output logic wdResetActive, // Watchdog reset in progress
  output logic standbyActive // Standby state
);
  import ppsm_pkg::*;

  localparam logic [WD_TMR_W-1:0] WD_TMR_LAST = WD_TMR_W'(WD_DELAY_CYC - 1);

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] ofs);
    regHit = (a == ofs);
  endfunction

  logic [6:0] sync1_q, sync2_q, sync3_q, flt_q;
  ppsm_pins_t pinF;
  logic powerOnPrev_q;
  ppsm_ctrl_t ctrl_q, ctrl_d;
  logic [WD_CNT_W-1:0] limit_q, limit_d, wdCount_q, wdCount_d;
  logic [WD_TMR_W-1:0] wdTimer_q;
  logic stErr_q, stErr_d, arrived_q, arrived_d;
  ppsm_state_t state_q, state_d;
  logic wrPhase_q;
  logic [7:0] addr_q;

  // Three-stage pin synchroniser, level accepted when stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      sync3_q <= 7'h00;
      flt_q <= 7'h00;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      flt_q <= (sync2_q & sync3_q) | (flt_q & (sync2_q | sync3_q));
    end
  end
  assign pinF = ppsm_pins_t'(flt_q);

  // Transition qualifiers
  wire powerOnFall = powerOnPrev_q & ~pinF.powerOnPin;
  wire powerOnEvt = ctrl_q.powerOnEdgeMode ? powerOnFall : pinF.powerOnPin;
  wire supplyOk = pinF.vinAboveUv & (~ctrl_q.ovloEnable | ~pinF.vinAboveOv);
  wire offQualOk = supplyOk & ~pinF.thermalShutdown & ~trimLoadError & ~configLoadError;
  wire loadErrClear = ~trimLoadError & ~configLoadError & ~stErr_q;
  wire extFailOk = ~ctrl_q.externalFailEnable | pinF.externalFailInput;
  wire standbyMatch = (pinF.standbyPin == ctrl_q.standbyPolarityBit);
  wire testMode = pinF.testModePin;
  wire wdAtLimit = (wdCount_q == limit_q);
  ppsm_state_t offExitState;
  assign offExitState = SAFETY_VARIANT ? ST_SELF_TEST : ST_QUICK_START_OFF_STATE;
  wire lpUserEvt = ~ctrl_q.quickPowerupSelect & ~testMode & powerOnEvt & offQualOk;

  // Next-state selection, earlier conditions win
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOW_POWER_OFF_STATE: begin
        if (testMode) begin
          state_d = ppsm_state_t'(offExitState);
        end else if (ctrl_q.quickPowerupSelect) begin
          state_d = ppsm_state_t'(offExitState);
        end else if (lpUserEvt) begin
          state_d = ppsm_state_t'(offExitState);
        end
      end
      ST_SELF_TEST: begin
        if (testMode || (selfTestDone && selfTestPass)) begin
          state_d = ST_QUICK_START_OFF_STATE;
        end else if (selfTestDone) begin
          state_d = ST_LOW_POWER_OFF_STATE;
        end
      end
      ST_QUICK_START_OFF_STATE: begin
        if (arrived_q && !ctrl_q.quickPowerupSelect && !testMode && loadErrClear
            && extFailOk) begin
          state_d = ST_POWER_UP;
        end else if ((ctrl_q.quickPowerupSelect || testMode) && powerOnEvt && offQualOk
                     && !stErr_q && extFailOk) begin
          state_d = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (powerUpSeqDone) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wdResetEvent) begin
          state_d = ST_WD_RESET;
        end else if (!standbyMatch) begin
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (wdResetEvent) begin
          state_d = ST_WD_RESET;
        end else if (standbyMatch) begin
          state_d = ST_RUN;
        end
      end
      ST_WD_RESET: begin
        if (wdAtLimit) begin
          state_d = ST_FAULT_DOWN;
        end else if (wdTimer_q == WD_TMR_LAST) begin
          state_d = ST_RUN;
        end
      end
      ST_FAULT_DOWN: begin
        if (powerDownDone) begin
          state_d = ST_LOW_POWER_OFF_STATE;
        end
      end
      default: state_d = ST_LOW_POWER_OFF_STATE;
    endcase
  end

  // Power-on arrival flag, watchdog count, self-test error
  wire enterWd = (state_d == ST_WD_RESET) & (state_q != ST_WD_RESET);
  wire stFailSet = (state_q == ST_SELF_TEST) & selfTestDone & ~selfTestPass & ~testMode;
  assign arrived_d = (state_q == ST_LOW_POWER_OFF_STATE) ? lpUserEvt
                   : (state_q == ST_POWER_UP) ? 1'b0 : arrived_q;
  assign wdCount_d = (enterWd && !wdAtLimit) ? wdCount_q + 1'b1
                   : (wrPhase_q && regHit(addr_q, COUNT_OFS)) ? '0 : wdCount_q;
  assign stErr_d = stFailSet | (stErr_q & ~(wrPhase_q & regHit(addr_q, STATUS_OFS)
                   & hwdata[STERR_POS]));

  // State register and watchdog delay timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_LOW_POWER_OFF_STATE;
      wdTimer_q <= '0;
      arrived_q <= 1'b0;
      wdCount_q <= '0;
      stErr_q <= 1'b0;
      powerOnPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wdTimer_q <= (state_q == ST_WD_RESET && state_d == ST_WD_RESET) ? wdTimer_q + 1'b1 : '0;
      arrived_q <= arrived_d;
      wdCount_q <= wdCount_d;
      stErr_q <= stErr_d;
      powerOnPrev_q <= pinF.powerOnPin;
    end
  end

  // Registered status outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      selfTestRun <= 1'b0;
      powerUpRun <= 1'b0;
      faultDownRun <= 1'b0;
      wdResetActive <= 1'b0;
      standbyActive <= 1'b0;
    end else begin
      selfTestRun <= (state_d == ST_SELF_TEST);
      powerUpRun <= (state_d == ST_POWER_UP);
      faultDownRun <= (state_d == ST_FAULT_DOWN);
      wdResetActive <= (state_d == ST_WD_RESET);
      standbyActive <= (state_d == ST_STANDBY);
    end
  end

  // AHB-Lite slave decode, zero wait states
  wire addrPhase = hsel & htrans[1] & hready;
  wire wrCtrl = wrPhase_q & regHit(addr_q, CTRL_OFS);
  wire wrLimit = wrPhase_q & regHit(addr_q, LIMIT_OFS);
  assign ctrl_d = wrCtrl ? ppsm_ctrl_t'(hwdata[4:0]) : ctrl_q;
  assign limit_d = wrLimit ? hwdata[WD_CNT_W-1:0] : limit_q;
  wire [31:0] readMux = regHit(haddr[7:0], CTRL_OFS) ? {27'h0, ctrl_d}
      : regHit(haddr[7:0], LIMIT_OFS) ? 32'(limit_d)
      : regHit(haddr[7:0], STATUS_OFS) ? (32'(stErr_d) << STERR_POS)
        | (32'(state_q) << STATE_POS)
      : regHit(haddr[7:0], COUNT_OFS) ? 32'(wdCount_d) : 32'h0;

  // Bus phase tracking and register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPhase_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= CTRL_RST;
      limit_q <= WD_CNT_W'(WD_LIMIT_RST);
    end else begin
      wrPhase_q <= addrPhase & hwrite;
      addr_q <= haddr[7:0];
      hrdata <= (addrPhase && !hwrite) ? readMux : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= ctrl_d;
      limit_q <= limit_d;
    end
  end

  // Checks of the transition behaviour
  run_to_standby_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_RUN && !wdResetEvent && !standbyMatch) |=> state_q == ST_STANDBY)
    else $error("run did not enter standby");
  standby_to_run_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_STANDBY && !wdResetEvent && standbyMatch) |=> state_q == ST_RUN)
    else $error("standby did not return to run");
  wd_entry_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ((state_q == ST_RUN || state_q == ST_STANDBY) && wdResetEvent) |=> wdResetActive)
    else $error("watchdog reset not entered");
  wd_exit_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q != ST_WD_RESET ##1 state_q == ST_WD_RESET && !wdAtLimit)
    |-> (state_q == ST_WD_RESET) [*8])
    else $error("watchdog reset left too early");
  wd_exit_time_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_WD_RESET && !wdAtLimit && wdTimer_q == WD_TMR_LAST) |=> state_q == ST_RUN)
    else $error("watchdog reset exit missed");
  wd_limit_fault_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_WD_RESET && wdAtLimit) |=> faultDownRun)
    else $error("watchdog limit did not fault");
  quick_select_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_LOW_POWER_OFF_STATE && ctrl_q.quickPowerupSelect && !testMode)
    |=> state_q == (SAFETY_VARIANT ? ST_SELF_TEST : ST_QUICK_START_OFF_STATE))
    else $error("quick select exit wrong");
  supply_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_LOW_POWER_OFF_STATE && !testMode && !ctrl_q.quickPowerupSelect && !supplyOk)
    |=> state_q == ST_LOW_POWER_OFF_STATE)
    else $error("left off with bad supply");
  ext_fail_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_QUICK_START_OFF_STATE && ctrl_q.externalFailEnable && !pinF.externalFailInput)
    |=> !powerUpRun)
    else $error("power-up with external fail low");
  edge_event_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_QUICK_START_OFF_STATE && ctrl_q.quickPowerupSelect && ctrl_q.powerOnEdgeMode
     && !powerOnFall) |=> state_q == ST_QUICK_START_OFF_STATE)
    else $error("edge mode started without edge");

  // Checks of the off-state and self-test exits, off-state holds and the watchdog delay hold
  level_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_LOW_POWER_OFF_STATE && !testMode && !ctrl_q.quickPowerupSelect
     && !ctrl_q.powerOnEdgeMode && pinF.powerOnPin && offQualOk)
    |=> state_q == (SAFETY_VARIANT ? ST_SELF_TEST : ST_QUICK_START_OFF_STATE))
    else $error("level power-on did not leave off");
  edge_lp_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_LOW_POWER_OFF_STATE && !testMode && !ctrl_q.quickPowerupSelect
     && ctrl_q.powerOnEdgeMode && !powerOnFall) |=> state_q == ST_LOW_POWER_OFF_STATE)
    else $error("edge mode left off without edge");
  test_mode_pass_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_LOW_POWER_OFF_STATE && testMode)
    |=> state_q == (SAFETY_VARIANT ? ST_SELF_TEST : ST_QUICK_START_OFF_STATE))
    else $error("test mode did not leave off");
  self_test_exit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_SELF_TEST && (testMode || (selfTestDone && selfTestPass)))
    |=> state_q == ST_QUICK_START_OFF_STATE)
    else $error("self-test exit missed");
  load_error_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_QUICK_START_OFF_STATE && (trimLoadError || configLoadError || stErr_q))
    |=> state_q == ST_QUICK_START_OFF_STATE)
    else $error("power-up with load error");
  thermal_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_QUICK_START_OFF_STATE && !arrived_q && pinF.thermalShutdown)
    |=> state_q == ST_QUICK_START_OFF_STATE)
    else $error("power-up in thermal shutdown");
  wd_timer_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == ST_WD_RESET && !wdAtLimit && wdTimer_q != WD_TMR_LAST)
    |=> state_q == ST_WD_RESET)
    else $error("watchdog reset left before delay");

endmodule

// File: bench/ppsm_host_model.sv
`timescale 1ns/100ps
module ppsm_host_model (
  input wire logic sys_clk, // Clock
  input wire logic wantPower, // Host asks for power-up
  input wire logic edgeMode, // Signal power-up by falling edge
  input wire logic wantStandby, // Host asks for standby
  input wire logic polarity, // Standby polarity in use
  output logic powerOnPin, // Power-on pin level
  output logic standbyPin // Standby pin level
);
  logic [3:0] holdCnt_q;

  // Counts how long the request has been held
  always @(posedge sys_clk) begin
    if (!wantPower) begin
      holdCnt_q <= 4'h0;
    end else if (holdCnt_q != 4'hf) begin
      holdCnt_q <= holdCnt_q + 4'h1;
    end
  end

  // Level mode holds high; edge mode gives a high pulse then a fall
  assign powerOnPin = edgeMode ? (wantPower && holdCnt_q < 4'h8) : wantPower;
  assign standbyPin = polarity ^ wantStandby;
endmodule

// File: bench/pmic_power_state_machine_bench.sv
`timescale 1ns/100ps
module pmic_power_state_machine_bench;
  import ppsm_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, wantPower = 0, wantStandby = 0, polarity = 0, edgeMode = 0;
  logic uvOk = 1, thermal = 0, wdEvent = 0, stDone = 0, puDone = 0, pdDone = 0;
  logic extFail = 1, testMode = 0, trimErr = 0;
  logic powerOnPin, standbyPin, stRun, puRun, fdRun, wdAct, sbAct;
  ppsm_pins_t pins;
  int n_fail = 0, total_checks = 0, cycles = 0;

  // Pins: no overvoltage
  assign pins = {standbyPin, powerOnPin, testMode, extFail, uvOk, 1'b0, thermal};

  ppsm_power_state_machine u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .trimLoadError(trimErr), .configLoadError(1'b0), .wdResetEvent(wdEvent),
    .selfTestDone(stDone), .selfTestPass(stDone), .powerUpSeqDone(puDone),
    .powerDownDone(pdDone), .selfTestRun(stRun), .powerUpRun(puRun),
    .faultDownRun(fdRun), .wdResetActive(wdAct), .standbyActive(sbAct));

  ppsm_host_model u_host (.sys_clk(sys_clk), .wantPower(wantPower), .edgeMode(edgeMode),
    .wantStandby(wantStandby), .polarity(polarity), .powerOnPin(powerOnPin),
    .standbyPin(standbyPin));

  // Clock and hang guard
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One single AHB transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Polls the state code a bounded number of times
  task automatic wait_state(input ppsm_state_t s, input int lim);
    for (int i = 0; i < lim; i++) begin
      ahb(1'b0, STATUS_OFS, '0);
      if (rd[3:0] === s) break;
    end
    check("state", {28'h0, s}, {28'h0, rd[3:0]});
  endtask

  task automatic wd_pulse;
    wdEvent <= 1'b1;
    @(posedge sys_clk);
    wdEvent <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    ahb(1'b0, CTRL_OFS, '0);
    check("ctrl", 32'h10, rd);
    wait_state(ST_LOW_POWER_OFF_STATE, 1);
    $display("test reset done");
    wantPower <= 1'b1;
    wait_state(ST_SELF_TEST, 20);
    check("selfTestRun", 32'h1, {31'h0, stRun});
    stDone <= 1'b1;
    puDone <= 1'b1;
    wait_state(ST_RUN, 20);
    wantPower <= 1'b0;
    $display("test power-up done");
    for (int p = 0; p < 2; p++) begin
      ahb(1'b1, CTRL_OFS, 32'h10 | p);
      polarity <= p[0];
      repeat (8) @(posedge sys_clk);
      wait_state(ST_RUN, 10);
      wantStandby <= 1'b1;
      wait_state(ST_STANDBY, 10);
      check("standbyActive", 32'h1, {31'h0, sbAct});
      wantStandby <= 1'b0;
      wait_state(ST_RUN, 10);
    end
    $display("test standby done");
    ahb(1'b1, LIMIT_OFS, 32'h2);
    ahb(1'b1, COUNT_OFS, '0);
    wd_pulse();
    wait_state(ST_WD_RESET, 2);
    check("wdResetActive", 32'h1, {31'h0, wdAct});
    repeat (WD_DELAY_CYC - 60) @(posedge sys_clk);
    wait_state(ST_WD_RESET, 1);
    wait_state(ST_RUN, 40);
    ahb(1'b0, COUNT_OFS, '0);
    check("count", 32'h1, rd);
    wd_pulse();
    wait_state(ST_FAULT_DOWN, 3);
    check("faultDownRun", 32'h1, {31'h0, fdRun});
    pdDone <= 1'b1;
    wait_state(ST_LOW_POWER_OFF_STATE, 5);
    $display("test watchdog done");
    ahb(1'b1, CTRL_OFS, 32'h15);
    edgeMode <= 1'b1;
    uvOk <= 1'b0;
    wantPower <= 1'b1;
    repeat (30) @(posedge sys_clk);
    wait_state(ST_LOW_POWER_OFF_STATE, 1);
    wantPower <= 1'b0;
    uvOk <= 1'b1;
    repeat (10) @(posedge sys_clk);
    wantPower <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wait_state(ST_LOW_POWER_OFF_STATE, 1);
    wait_state(ST_RUN, 40);
    $display("test edge mode done");
    extFail <= 1'b0;
    wd_pulse();
    wait_state(ST_LOW_POWER_OFF_STATE, 5);
    ahb(1'b1, CTRL_OFS, 32'h1f);
    wait_state(ST_QUICK_START_OFF_STATE, 10);
    wantPower <= 1'b0;
    @(posedge sys_clk);
    wantPower <= 1'b1;
    repeat (20) @(posedge sys_clk);
    wait_state(ST_QUICK_START_OFF_STATE, 1);
    check("powerUpRun", 32'h0, {31'h0, puRun});
    extFail <= 1'b1;
    wantPower <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wantPower <= 1'b1;
    wait_state(ST_RUN, 20);
    $display("test quick select done");
    wantPower <= 1'b0;
    edgeMode <= 1'b0;
    testMode <= 1'b1;
    thermal <= 1'b1;
    ahb(1'b1, CTRL_OFS, 32'h11);
    wd_pulse();
    wait_state(ST_QUICK_START_OFF_STATE, 10);
    trimErr <= 1'b1;
    wantPower <= 1'b1;
    repeat (10) @(posedge sys_clk);
    wait_state(ST_QUICK_START_OFF_STATE, 1);
    trimErr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wait_state(ST_QUICK_START_OFF_STATE, 1);
    thermal <= 1'b0;
    wait_state(ST_RUN, 20);
    testMode <= 1'b0;
    $display("test mode done");
    tally_and_finish();
  end
endmodule
